/* File: common/bfp_pkg.sv */
// Shared constants, encodings and helper functions for the two-way queue port block.
// Assumes both queues are 64 words of 36 bits and that every pointer is 7 bits wide.
package bfp_pkg;

  localparam int unsigned DATA_W = 36;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned PTR_W = 7;
  localparam int unsigned ADDR_W = 6;

  // Fill counts and the offset are held at pointer width; the almost-full sum is compared one bit wider.
  localparam logic [6:0] DEPTH_COUNT = 7'h40;
  localparam logic [6:0] EMPTY_COUNT = 7'h00;
  localparam logic [6:0] PTR_RESET = 7'h00;

  // Offset values picked by the two fill-level inputs at reset release.
  localparam logic [6:0] OFFSET_PICK_HH = 7'h10;
  localparam logic [6:0] OFFSET_PICK_HL = 7'h0C;
  localparam logic [6:0] OFFSET_PICK_LH = 7'h08;
  localparam logic [6:0] OFFSET_PICK_LL = 7'h04;
  localparam logic [6:0] OFFSET_RESET = 7'h04;

  // The write side holds its room flag low for two own-clock edges after reset.
  localparam logic [1:0] ROOM_HOLD_RESET = 2'h0;

  localparam logic [35:0] DATA_RESET = 36'h0_0000_0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Bit positions of the decoded port operation.
  localparam int unsigned OP_WR_FIFO = 0;
  localparam int unsigned OP_WR_MAIL = 1;
  localparam int unsigned OP_RD_FIFO = 2;
  localparam int unsigned OP_RD_MAIL = 3;
  localparam int unsigned OP_W = 4;

  function automatic logic [6:0] bin_to_gray(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [6:0] gray_to_bin(input logic [6:0] g);
    logic [6:0] b;
    b = g;
    for (int i = 5; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  // One port's select, direction, strobe gate and mailbox pick into four operations.
  function automatic logic [3:0] port_decode(input logic cs_n, input logic dir, input logic gate, input logic mb);
    logic [3:0] op;
    logic sel;
    sel = ~cs_n & gate;
    op = 4'h0;
    op[OP_WR_FIFO] = sel & dir & ~mb;
    op[OP_WR_MAIL] = sel & dir & mb;
    op[OP_RD_FIFO] = sel & ~dir & ~mb;
    op[OP_RD_MAIL] = sel & ~dir & mb;
    return op;
  endfunction

  function automatic logic [6:0] offset_decode(input logic pick1, input logic pick0);
    logic [6:0] x;
    unique case ({pick1, pick0})
      2'h3: x = OFFSET_PICK_HH;
      2'h2: x = OFFSET_PICK_HL;
      2'h1: x = OFFSET_PICK_LH;
      2'h0: x = OFFSET_PICK_LL;
    endcase
    return x;
  endfunction

endpackage

/* File: hw/bfp_queue.sv */
// One 64 x 36 queue with its write side on one clock and its read side on another.
// Assumes each side gets a synchronous reset already timed to its own clock.
`timescale 1ns/1ps
module bfp_queue (
  input wire logic wr_clk, // writing port clock
  input wire logic wr_rst, // reset in write domain, active high
  input wire logic [6:0] wr_offset, // offset as held in write domain
  input wire logic wr_req, // write requested this edge
  input wire logic [35:0] wr_data, // word to store
  output logic wr_room_n, // high while a slot is free
  output logic wr_high_fill_n, // low at DEPTH minus offset words or more
  input wire logic rd_clk, // reading port clock
  input wire logic rd_rst, // reset in read domain, active high
  input wire logic [6:0] rd_offset, // offset as held in read domain
  input wire logic rd_req, // read requested this edge
  output logic [35:0] rd_data, // output register
  output logic rd_nothing_n, // high while a word can be read
  output logic rd_low_fill_n // high above offset words
);

  logic [35:0] mem_q [0:bfp_pkg::DEPTH-1];
  logic [6:0] wbin_q;
  logic [6:0] wgray_q;
  logic [6:0] rbin_q;
  logic [6:0] rgray_q;
  logic [6:0] wsync1_q;
  logic [6:0] wsync2_q;
  logic [6:0] rsync1_q;
  logic [6:0] rsync2_q;
  logic [1:0] room_hold_q;
  logic [35:0] rd_data_q;
  logic [6:0] wr_fill;
  logic [6:0] rd_fill;
  logic wr_take;
  logic rd_take;

  // Write-side fill from own pointer and synchronised read pointer.
  assign wr_fill = wbin_q - bfp_pkg::gray_to_bin(rsync2_q);
  // Read-side fill, seen only after the pointer crossing.
  assign rd_fill = bfp_pkg::gray_to_bin(wsync2_q) - rbin_q;

  // Room stays low until two write-clock edges after reset.
  assign wr_room_n = room_hold_q[1] & (wr_fill != bfp_pkg::DEPTH_COUNT);
  // Almost-full low at DEPTH minus offset or more.
  assign wr_high_fill_n = ({1'b0, wr_fill} + {1'b0, wr_offset}) < {1'b0, bfp_pkg::DEPTH_COUNT};
  // Not-empty follows the second synchroniser stage directly.
  assign rd_nothing_n = rd_fill != bfp_pkg::EMPTY_COUNT;
  // Almost-empty high from offset plus one words.
  assign rd_low_fill_n = rd_fill > rd_offset;
  assign rd_data = rd_data_q;

  // Writes are dropped while no slot is free.
  assign wr_take = wr_req & wr_room_n;
  // Reads are dropped while the queue looks empty here.
  assign rd_take = rd_req & rd_nothing_n;

  always_ff @(posedge wr_clk)
  begin
    if (wr_take)
    begin
      mem_q[wbin_q[bfp_pkg::ADDR_W-1:0]] <= wr_data;
    end
  end

  // Write pointer steps once per stored word, kept in both codes.
  always_ff @(posedge wr_clk)
  begin
    if (wr_rst)
    begin
      wbin_q <= bfp_pkg::PTR_RESET;
      wgray_q <= bfp_pkg::PTR_RESET;
    end
    else if (wr_take)
    begin
      wbin_q <= wbin_q + 7'h01;
      wgray_q <= bfp_pkg::bin_to_gray(wbin_q + 7'h01);
    end
  end

  always_ff @(posedge wr_clk)
  begin
    if (wr_rst)
    begin
      room_hold_q <= bfp_pkg::ROOM_HOLD_RESET;
    end
    else
    begin
      room_hold_q <= {room_hold_q[0], 1'b1};
    end
  end

  // Read pointer reaches write side through two stages.
  // Only the gray-coded pointer crosses, one bit changing per step.
  always_ff @(posedge wr_clk)
  begin
    if (wr_rst)
    begin
      rsync1_q <= bfp_pkg::PTR_RESET;
      rsync2_q <= bfp_pkg::PTR_RESET;
    end
    else
    begin
      rsync1_q <= rgray_q;
      rsync2_q <= rsync1_q;
    end
  end

  // Read pointer steps each time the output register loads.
  always_ff @(posedge rd_clk)
  begin
    if (rd_rst)
    begin
      rbin_q <= bfp_pkg::PTR_RESET;
      rgray_q <= bfp_pkg::PTR_RESET;
      rd_data_q <= bfp_pkg::DATA_RESET;
    end
    else if (rd_take)
    begin
      rbin_q <= rbin_q + 7'h01;
      rgray_q <= bfp_pkg::bin_to_gray(rbin_q + 7'h01);
      rd_data_q <= mem_q[rbin_q[bfp_pkg::ADDR_W-1:0]];
    end
  end

  // Write pointer reaches read side through two stages.
  // A write just before an edge slips to the next edge here.
  always_ff @(posedge rd_clk)
  begin
    if (rd_rst)
    begin
      wsync1_q <= bfp_pkg::PTR_RESET;
      wsync2_q <= bfp_pkg::PTR_RESET;
    end
    else
    begin
      wsync1_q <= wgray_q;
      wsync2_q <= wsync1_q;
    end
  end

endmodule // bfp_queue

/* File: hw/bfp_top.sv */
// Two-way queue port block: port decode, two queues, two mail registers and their flags.
// Port A runs on core_clk, port B on port_b_clock; the two clocks are unrelated.
`timescale 1ns/1ps
module bfp_top (
  input wire logic core_clk, // port A clock
  input wire logic srst, // synchronous reset, active high
  input wire logic port_b_clock, // port B clock, unrelated to core_clk
  input wire logic fill_level_pick_0, // offset select, low bit
  input wire logic fill_level_pick_1, // offset select, high bit
  input wire logic port_a_chip_select_n, // port A select, active low
  input wire logic port_a_direction, // port A high write, low read
  input wire logic port_a_strobe_gate, // port A enable
  input wire logic port_a_mailbox_pick, // port A high mail, low queue
  input wire logic [35:0] port_a_data_in, // port A bus level
  output logic [35:0] port_a_data_out, // port A bus drive value
  output logic port_a_data_oe, // port A bus driven while high
  input wire logic port_b_chip_select_n, // port B select, active low
  input wire logic port_b_direction, // port B high write, low read
  input wire logic port_b_strobe_gate, // port B enable
  input wire logic port_b_mailbox_pick, // port B high mail, low queue
  input wire logic [35:0] port_b_data_in, // port B bus level
  output logic [35:0] port_b_data_out, // port B bus drive value
  output logic port_b_data_oe, // port B bus driven while high
  output logic a_side_nothing_flag_n, // queue two not empty, core_clk
  output logic a_side_low_fill_flag_n, // queue two above offset, core_clk
  output logic a_side_no_room_flag_n, // queue one not full, core_clk
  output logic a_side_high_fill_flag_n, // queue one not almost full, core_clk
  output logic b_side_nothing_flag_n, // queue one not empty, port_b_clock
  output logic b_side_low_fill_flag_n, // queue one above offset, port_b_clock
  output logic b_side_no_room_flag_n, // queue two not full, port_b_clock
  output logic b_side_high_fill_flag_n, // queue two not almost full, port_b_clock
  output logic mail_one_flag_n, // low while mail one unread, core_clk
  output logic mail_two_flag_n // low while mail two unread, port_b_clock
);

  logic [1:0] pick_meta_q;
  logic [1:0] pick_sync_q;
  logic [6:0] offset_a_q;
  logic [6:0] offset_b_q;
  logic b_rst_meta_q;
  logic b_rst_q;
  logic [3:0] a_op;
  logic [3:0] b_op;
  logic [35:0] q1_rd_data;
  logic [35:0] q2_rd_data;
  logic [35:0] mail_one_q;
  logic [35:0] mail_two_q;
  logic m1_put_q;
  logic m1_get_q;
  logic m1_put_meta_q;
  logic m1_put_sync_q;
  logic m1_get_meta_q;
  logic m1_get_sync_q;
  logic m2_put_q;
  logic m2_get_q;
  logic m2_put_meta_q;
  logic m2_put_sync_q;
  logic m2_get_meta_q;
  logic m2_get_sync_q;

  // Port A strobes decoded on its own clock.
  assign a_op = bfp_pkg::port_decode(port_a_chip_select_n, port_a_direction, port_a_strobe_gate,
                                     port_a_mailbox_pick);
  // Port B strobes decoded on its own clock.
  assign b_op = bfp_pkg::port_decode(port_b_chip_select_n, port_b_direction, port_b_strobe_gate,
                                     port_b_mailbox_pick);

  // The fill picks are pins with no timing to core_clk, so they are resampled first.
  always_ff @(posedge core_clk)
  begin
    pick_meta_q <= {fill_level_pick_1, fill_level_pick_0};
    pick_sync_q <= pick_meta_q;
  end

  // The last reset cycle sets the offset, so the release edge keeps it.
  // This offset serves both port A partial-fill flags; the port B flags use the copy held in offset_b_q.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      offset_a_q <= bfp_pkg::offset_decode(pick_sync_q[1], pick_sync_q[0]);
    end
  end

  // Port B sees reset two of its own edges late, so its side never leaves reset first.
  always_ff @(posedge port_b_clock)
  begin
    b_rst_meta_q <= srst;
    b_rst_q <= b_rst_meta_q;
  end

  // The offset is frozen once core reset ends, and port B copies it only while still held in reset.
  always_ff @(posedge port_b_clock)
  begin
    if (b_rst_q)
    begin
      offset_b_q <= offset_a_q;
    end
  end

  // Queue one: written on port A, read on port B.
  bfp_queue u_queue_one (
    .wr_clk(core_clk),
    .wr_rst(srst),
    .wr_offset(offset_a_q),
    .wr_req(a_op[bfp_pkg::OP_WR_FIFO]),
    .wr_data(port_a_data_in),
    .wr_room_n(a_side_no_room_flag_n),
    .wr_high_fill_n(a_side_high_fill_flag_n),
    .rd_clk(port_b_clock),
    .rd_rst(b_rst_q),
    .rd_offset(offset_b_q),
    .rd_req(b_op[bfp_pkg::OP_RD_FIFO]),
    .rd_data(q1_rd_data),
    .rd_nothing_n(b_side_nothing_flag_n),
    .rd_low_fill_n(b_side_low_fill_flag_n)
  );

  // Queue two: written on port B, read on port A.
  bfp_queue u_queue_two (
    .wr_clk(port_b_clock),
    .wr_rst(b_rst_q),
    .wr_offset(offset_b_q),
    .wr_req(b_op[bfp_pkg::OP_WR_FIFO]),
    .wr_data(port_b_data_in),
    .wr_room_n(b_side_no_room_flag_n),
    .wr_high_fill_n(b_side_high_fill_flag_n),
    .rd_clk(core_clk),
    .rd_rst(srst),
    .rd_offset(offset_a_q),
    .rd_req(a_op[bfp_pkg::OP_RD_FIFO]),
    .rd_data(q2_rd_data),
    .rd_nothing_n(a_side_nothing_flag_n),
    .rd_low_fill_n(a_side_low_fill_flag_n)
  );

  // Mail one: port A writes and toggles put, port B reads and toggles get.
  // The flag is low while put and get disagree as seen in the core_clk domain.
  // A mail write is taken only while the mail one flag is high.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      m1_put_q <= 1'b0;
      mail_one_q <= bfp_pkg::DATA_RESET;
    end
    else if (a_op[bfp_pkg::OP_WR_MAIL] && mail_one_flag_n)
    begin
      m1_put_q <= ~m1_put_q;
      mail_one_q <= port_a_data_in;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      m1_get_meta_q <= 1'b0;
      m1_get_sync_q <= 1'b0;
    end
    else
    begin
      m1_get_meta_q <= m1_get_q;
      m1_get_sync_q <= m1_get_meta_q;
    end
  end

  always_ff @(posedge port_b_clock)
  begin
    if (b_rst_q)
    begin
      m1_put_meta_q <= 1'b0;
      m1_put_sync_q <= 1'b0;
    end
    else
    begin
      m1_put_meta_q <= m1_put_q;
      m1_put_sync_q <= m1_put_meta_q;
    end
  end

  // A port B mail read releases mail one once the pending mail is visible here.
  always_ff @(posedge port_b_clock)
  begin
    if (b_rst_q)
    begin
      m1_get_q <= 1'b0;
    end
    else if (b_op[bfp_pkg::OP_RD_MAIL] && (m1_put_sync_q != m1_get_q))
    begin
      m1_get_q <= m1_put_sync_q;
    end
  end

  // Mail two mirrors mail one with the ports swapped.
  // A mail write is taken only while the mail two flag is high.
  always_ff @(posedge port_b_clock)
  begin
    if (b_rst_q)
    begin
      m2_put_q <= 1'b0;
      mail_two_q <= bfp_pkg::DATA_RESET;
    end
    else if (b_op[bfp_pkg::OP_WR_MAIL] && mail_two_flag_n)
    begin
      m2_put_q <= ~m2_put_q;
      mail_two_q <= port_b_data_in;
    end
  end

  always_ff @(posedge port_b_clock)
  begin
    if (b_rst_q)
    begin
      m2_get_meta_q <= 1'b0;
      m2_get_sync_q <= 1'b0;
    end
    else
    begin
      m2_get_meta_q <= m2_get_q;
      m2_get_sync_q <= m2_get_meta_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      m2_put_meta_q <= 1'b0;
      m2_put_sync_q <= 1'b0;
    end
    else
    begin
      m2_put_meta_q <= m2_put_q;
      m2_put_sync_q <= m2_put_meta_q;
    end
  end

  // A port A mail read releases mail two once the pending mail is visible here.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      m2_get_q <= 1'b0;
    end
    else if (a_op[bfp_pkg::OP_RD_MAIL] && (m2_put_sync_q != m2_get_q))
    begin
      m2_get_q <= m2_put_sync_q;
    end
  end

  // Equal toggles after reset leave both mail flags high.
  assign mail_one_flag_n = m1_put_q == m1_get_sync_q;
  assign mail_two_flag_n = m2_put_q == m2_get_sync_q;

  // The mail word from the far domain is driven whenever the pick selects it; no flag gates it.
  // Port A drives while selected for reading; the pick chooses the source.
  assign port_a_data_oe = ~port_a_chip_select_n & ~port_a_direction;
  assign port_a_data_out = port_a_mailbox_pick ? mail_two_q : q2_rd_data;
  // Port B drives while selected for reading; the pick chooses the source.
  assign port_b_data_oe = ~port_b_chip_select_n & ~port_b_direction;
  assign port_b_data_out = port_b_mailbox_pick ? mail_one_q : q1_rd_data;

endmodule // bfp_top

/* File: tb/bfp_checker.sv */
// Port-level checks for the two-way queue block, bound onto bfp_top.
// Assumes srst is synchronous to core_clk and also quiets the port B checks.
`timescale 1ns/1ps
module bfp_checker (
  input wire logic core_clk, // port A clock
  input wire logic srst, // reset
  input wire logic port_b_clock, // port B clock
  input wire logic port_a_chip_select_n, // A select
  input wire logic port_a_direction, // A direction
  input wire logic port_a_strobe_gate, // A enable
  input wire logic port_a_mailbox_pick, // A pick
  input wire logic [35:0] port_a_data_out, // A drive value
  input wire logic port_a_data_oe, // A drive enable
  input wire logic port_b_chip_select_n, // B select
  input wire logic port_b_direction, // B direction
  input wire logic port_b_strobe_gate, // B enable
  input wire logic port_b_mailbox_pick, // B pick
  input wire logic [35:0] port_b_data_out, // B drive value
  input wire logic port_b_data_oe, // B drive enable
  input wire logic a_side_nothing_flag_n, // A empty
  input wire logic a_side_low_fill_flag_n, // A almost empty
  input wire logic a_side_no_room_flag_n, // A full
  input wire logic a_side_high_fill_flag_n, // A almost full
  input wire logic b_side_nothing_flag_n, // B empty
  input wire logic b_side_low_fill_flag_n, // B almost empty
  input wire logic mail_one_flag_n, // mail one
  input wire logic mail_two_flag_n // mail two
);
  sequence a_sel;
    !port_a_chip_select_n && port_a_strobe_gate;
  endsequence
  sequence a_rd_q;
    a_sel and (!port_a_direction && !port_a_mailbox_pick && !a_side_nothing_flag_n);
  endsequence
  sequence a_mail_put;
    a_sel and (port_a_direction && port_a_mailbox_pick);
  endsequence
  sequence a_mail_get;
    a_sel and (!port_a_direction && port_a_mailbox_pick);
  endsequence
  sequence b_rd_q;
    !port_b_chip_select_n && port_b_strobe_gate && !port_b_direction && !port_b_mailbox_pick && !b_side_nothing_flag_n;
  endsequence
  sequence b_mail_put;
    !port_b_chip_select_n && port_b_strobe_gate && port_b_direction && port_b_mailbox_pick;
  endsequence
  // The room flag needs two own edges after release before it may rise.
  sequence room_wakeup;
    !a_side_no_room_flag_n ##1 !a_side_no_room_flag_n ##1 a_side_no_room_flag_n;
  endsequence
  a_port_a_drive: assert property (@(posedge core_clk) disable iff (srst)
    port_a_data_oe == (!port_a_chip_select_n && !port_a_direction)) else $error("port A drive enable wrong");
  a_port_b_drive: assert property (@(posedge port_b_clock) disable iff (srst)
    port_b_data_oe == (!port_b_chip_select_n && !port_b_direction)) else $error("port B drive enable wrong");
  // The offset reaches its register only after the picks pass two stages, so flags are judged at the fourth edge.
  a_reset_flags: assert property (@(posedge core_clk) srst [*4] |-> !a_side_nothing_flag_n &&
    !a_side_low_fill_flag_n && !a_side_no_room_flag_n && a_side_high_fill_flag_n && mail_one_flag_n)
    else $error("flags wrong in reset");
  a_room_wake: assert property (@(posedge core_clk) $fell(srst) |-> room_wakeup)
    else $error("room flag wake wrong");
  a_mail_one_set: assert property (@(posedge core_clk) disable iff (srst) a_mail_put |=> !mail_one_flag_n)
    else $error("mail one flag not set");
  a_mail_two_free: assert property (@(posedge core_clk) disable iff (srst) a_mail_get |-> ##[1:3] mail_two_flag_n)
    else $error("mail two flag not released");
  a_mail_two_set: assert property (@(posedge port_b_clock) disable iff (srst) b_mail_put |=> !mail_two_flag_n)
    else $error("mail two flag not set");
  a_a_empty_read: assert property (@(posedge core_clk) disable iff (srst)
    a_rd_q |=> port_a_mailbox_pick || $stable(port_a_data_out)) else $error("port A read while empty");
  a_b_empty_read: assert property (@(posedge port_b_clock) disable iff (srst)
    b_rd_q |=> port_b_mailbox_pick || $stable(port_b_data_out)) else $error("port B read while empty");
  a_full_fall: assert property (@(posedge core_clk) disable iff (srst)
    $fell(a_side_no_room_flag_n) |-> !a_side_high_fill_flag_n) else $error("full without almost full");
  a_fill_order: assert property (@(posedge core_clk) disable iff (srst)
    a_side_low_fill_flag_n |-> a_side_nothing_flag_n) else $error("almost empty above empty");
endmodule // bfp_checker

bind bfp_top bfp_checker u_chk (.core_clk(core_clk), .srst(srst), .port_b_clock(port_b_clock),
  .port_a_chip_select_n(port_a_chip_select_n), .port_a_direction(port_a_direction),
  .port_a_strobe_gate(port_a_strobe_gate), .port_a_mailbox_pick(port_a_mailbox_pick),
  .port_a_data_out(port_a_data_out), .port_a_data_oe(port_a_data_oe),
  .port_b_chip_select_n(port_b_chip_select_n), .port_b_direction(port_b_direction),
  .port_b_strobe_gate(port_b_strobe_gate), .port_b_mailbox_pick(port_b_mailbox_pick),
  .port_b_data_out(port_b_data_out), .port_b_data_oe(port_b_data_oe),
  .a_side_nothing_flag_n(a_side_nothing_flag_n), .a_side_low_fill_flag_n(a_side_low_fill_flag_n),
  .a_side_no_room_flag_n(a_side_no_room_flag_n), .a_side_high_fill_flag_n(a_side_high_fill_flag_n),
  .b_side_nothing_flag_n(b_side_nothing_flag_n), .b_side_low_fill_flag_n(b_side_low_fill_flag_n),
  .mail_one_flag_n(mail_one_flag_n), .mail_two_flag_n(mail_two_flag_n));

/* File: tb/bfp_port_b_host.sv */
// Port B host model: a bus master issuing one access per task call.
// Assumes the bench supplies port_b_clock and calls b_op one access at a time.
`timescale 1ns/1ps
module bfp_port_b_host (
  input wire logic port_b_clock, // port B clock
  output logic port_b_chip_select_n, // select, active low
  output logic port_b_direction, // high write
  output logic port_b_strobe_gate, // enable
  output logic port_b_mailbox_pick, // high mail
  output logic [35:0] port_b_data_in, // bus level
  input wire logic [35:0] port_b_data_out, // device drive value
  input wire logic port_b_data_oe // device drives while high
);
  logic [35:0] drv;
  initial
  begin
    port_b_chip_select_n = 1'b1;
    port_b_direction = 1'b0;
    port_b_strobe_gate = 1'b0;
    port_b_mailbox_pick = 1'b0;
    drv = 36'h0_0000_0000;
  end
  // A released bus shows the inverse of the last level, so stale data never passes as fresh.
  assign port_b_data_in = port_b_data_oe ? port_b_data_out : drv;
  // access held across one rising edge.
  task automatic b_op(input logic gate, dir, pick, input logic [35:0] d, output logic [35:0] q);
    @(negedge port_b_clock);
    port_b_chip_select_n = 1'b0;
    port_b_direction = dir;
    port_b_strobe_gate = gate;
    port_b_mailbox_pick = pick;
    drv = d;
    @(negedge port_b_clock);
    q = port_b_data_out;
    port_b_chip_select_n = 1'b1;
    port_b_strobe_gate = 1'b0;
    drv = ~d;
  endtask
endmodule // bfp_port_b_host

/* File: tb/tb_top.sv */
// Bench for the two-way queue block: port A driven here, port B through the host model.
// Assumes core_clk of 50 ns and a 6 ns port B clock of unrelated phase.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic b_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] pick = 2'h0;
  logic a_cs_n = 1'b1, a_dir = 1'b0, a_gate = 1'b0, a_pick = 1'b0;
  logic [35:0] a_drv = 36'h0_0000_0000;
  logic [35:0] a_dout, b_dout, b_din, rd;
  logic a_oe, b_oe, b_cs_n, b_dir, b_gate, b_pick, m1, m2;
  logic [3:0] fa, fb;
  int xval[4] = '{4, 8, 12, 16};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 core_clk = ~core_clk;
  initial
  begin
    #1.3;
    forever #3 b_clk = ~b_clk;
  end
  bfp_top dut (.core_clk(core_clk), .srst(srst), .port_b_clock(b_clk),
    .fill_level_pick_0(pick[0]), .fill_level_pick_1(pick[1]), .port_a_chip_select_n(a_cs_n),
    .port_a_direction(a_dir), .port_a_strobe_gate(a_gate), .port_a_mailbox_pick(a_pick),
    .port_a_data_in(a_oe ? a_dout : a_drv), .port_a_data_out(a_dout), .port_a_data_oe(a_oe),
    .port_b_chip_select_n(b_cs_n), .port_b_direction(b_dir), .port_b_strobe_gate(b_gate),
    .port_b_mailbox_pick(b_pick), .port_b_data_in(b_din), .port_b_data_out(b_dout), .port_b_data_oe(b_oe),
    .a_side_nothing_flag_n(fa[3]), .a_side_low_fill_flag_n(fa[2]), .a_side_no_room_flag_n(fa[1]),
    .a_side_high_fill_flag_n(fa[0]), .b_side_nothing_flag_n(fb[3]), .b_side_low_fill_flag_n(fb[2]),
    .b_side_no_room_flag_n(fb[1]), .b_side_high_fill_flag_n(fb[0]), .mail_one_flag_n(m1), .mail_two_flag_n(m2));
  bfp_port_b_host host (.port_b_clock(b_clk), .port_b_chip_select_n(b_cs_n), .port_b_direction(b_dir),
    .port_b_strobe_gate(b_gate), .port_b_mailbox_pick(b_pick), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_data_oe(b_oe));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check_data(input string what, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_flags(input string what, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  function automatic logic [3:0] fill_exp(input int n, input int x);
    return {n != 0, n > x, n != 64, n < 64 - x};
  endfunction
  function automatic logic [35:0] word(input bit two, input int n);
    return {3'h5, two, 24'h3C_A500, 8'(n)};
  endfunction
  function automatic logic [3:0] qflags(input bit two);
    return two ? {fa[3:2], fb[1:0]} : {fb[3:2], fa[1:0]};
  endfunction
  // Flags cross in two or three edges; four core cycles covers both domains.
  task automatic settle();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic op(input bit pb, input logic gate, dir, pick, input logic [35:0] d, output logic [35:0] q);
    if (pb)
      host.b_op(gate, dir, pick, d, q);
    else
    begin
      @(negedge core_clk);
      a_cs_n = 1'b0;
      a_dir = dir;
      a_gate = gate;
      a_pick = pick;
      a_drv = d;
      @(negedge core_clk);
      q = a_dout;
      a_cs_n = 1'b1;
      a_gate = 1'b0;
      a_drv = ~d;
    end
  endtask
  task automatic do_reset(input logic [1:0] p);
    pick = p;
    @(negedge core_clk);
    srst = 1'b1;
    repeat (4) @(negedge core_clk);
    check_flags("reset flags", 10'h047, {fa, fb, m1, m2});
    srst = 1'b0;
    @(negedge core_clk);
    check_flags("room after one edge", 10'h000, {9'h000, fa[1]});
    @(negedge core_clk);
    check_flags("room after two edges", 10'h001, {9'h000, fa[1]});
    repeat (4) @(negedge core_clk);
  endtask
  task automatic run_queue(input bit two, input int x);
    op(two, 1'b0, 1'b1, 1'b0, 36'hF_FFFF_FFFF, rd);
    for (int n = 1; n <= 65; n++)
    begin
      op(two, 1'b1, 1'b1, 1'b0, word(two, n), rd);
      settle();
      check_flags("fill flags", {6'h00, fill_exp(n > 64 ? 64 : n, x)}, {6'h00, qflags(two)});
    end
    for (int n = 63; n >= -1; n--)
    begin
      op(!two, 1'b1, 1'b0, 1'b0, 36'h0_0000_0000, rd);
      settle();
      check_data("read word", word(two, n < 0 ? 64 : 64 - n), rd);
      check_flags("drain flags", {6'h00, fill_exp(n < 0 ? 0 : n, x)}, {6'h00, qflags(two)});
    end
  endtask
  task automatic mail_test();
    op(1'b0, 1'b1, 1'b1, 1'b1, 36'h1_2345_6789, rd);
    settle();
    check_flags("mail one flag", 10'h000, {9'h000, m1});
    op(1'b0, 1'b1, 1'b1, 1'b1, 36'hE_DCBA_9876, rd);
    op(1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0000, rd);
    check_data("mail one word", 36'h1_2345_6789, rd);
    settle();
    check_flags("mail one freed", 10'h001, {9'h000, m1});
    op(1'b1, 1'b1, 1'b1, 1'b1, 36'h0_0F0F_A5A5, rd);
    settle();
    check_flags("mail two flag", 10'h000, {9'h000, m2});
    op(1'b0, 1'b1, 1'b0, 1'b1, 36'h0_0000_0000, rd);
    check_data("mail two word", 36'h0_0F0F_A5A5, rd);
    settle();
    check_flags("mail two freed", 10'h001, {9'h000, m2});
  endtask
  initial
  begin
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    // The room flag must finish waking before the next reset, or its wake-up check fails.
    repeat (2) @(negedge core_clk);
    for (int p = 0; p < 4; p++)
    begin
      do_reset(2'(p));
      run_queue(1'b0, xval[p]);
      run_queue(1'b1, xval[p]);
    end
    mail_test();
    print_verdict();
  end
endmodule // tb_top
